// file: core/uec_map.svh
// register offsets, field positions and reset values of the usb control block
`ifndef UEC_MAP_SVH
`define UEC_MAP_SVH
// byte offsets on the register bus
`define UEC_CFG_OFS 8'h00
`define UEC_PWR_OFS 8'h04
`define UEC_EP_BASE 8'h40
`define UEC_EP_LAST 8'h7c
// configuration register fields
`define UEC_CFG_EYE 7
`define UEC_CFG_OEMON 6
`define UEC_CFG_SIDL 4
`define UEC_CFG_ASUSP 0
`define UEC_CFG_MASK 8'hd1
// power control register fields
`define UEC_PWR_SUSP 1
`define UEC_PWR_MASK 8'h02
// endpoint control register fields
`define UEC_EP_LSD 7
`define UEC_EP_RDIS 6
`define UEC_EP_CDIS 4
`define UEC_EP_RXEN 3
`define UEC_EP_TXEN 2
`define UEC_EP_STALL 1
`define UEC_EP_HSHK 0
`define UEC_EP_MASK 8'hdf
// reset value of every implemented field
`define UEC_RST_VAL 8'h00
// bus response codes
`define UEC_RESP_OKAY 2'b00
`define UEC_RESP_SLVERR 2'b10
`endif

// file: core/uec_pkg.sv
// types shared by the usb control block files
package uec_pkg;
  // token kinds offered by the protocol engine
  typedef enum logic [1:0] {
    UEC_PID_OUT = 2'h0,
    UEC_PID_IN = 2'h1,
    UEC_PID_SETUP = 2'h3
  } uec_pid_t;
  // one token awaiting an endpoint decision
  typedef struct packed {
    logic valid;
    logic [3:0] ep;
    uec_pid_t pid;
  } uec_tok_t;
  // one register write toward the register file
  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } uec_bus_req_t;
  // write channel state, gray along idle to response
  typedef enum logic [1:0] {
    UEC_WR_IDLE = 2'b00,
    UEC_WR_RESP = 2'b01
  } uec_wr_state_t;
endpackage

// file: core/uec_axil_slave.sv
// axi4-lite slave front end of the usb control registers
`timescale 1ns/1ps
`default_nettype none
`include "uec_map.svh"
module uec_axil_slave (
  // clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // write address channel
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  // write data channel
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  // write response channel
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  // read address channel
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  // read data channel
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // register file side
  output var uec_pkg::uec_bus_req_t wr_req_out,
  input wire logic wr_hit_in,
  output logic rd_en_out,
  output logic [7:0] rd_addr_out,
  input wire logic [31:0] rd_data_in,
  input wire logic rd_hit_in
);
  uec_pkg::uec_wr_state_t wr_state_ff; // write channel state
  logic aw_held_ff; // address taken, waiting for data
  logic w_held_ff; // data taken, waiting for address
  logic [7:0] aw_addr_ff; // held write address
  logic [31:0] w_data_ff; // held write data
  logic [3:0] w_strb_ff; // held byte strobes
  logic commit; // both halves present
  // each half is taken once and parked until the pair commits
  assign s_axi_awready_out = !aw_held_ff && (wr_state_ff == uec_pkg::UEC_WR_IDLE);
  assign s_axi_wready_out = !w_held_ff && (wr_state_ff == uec_pkg::UEC_WR_IDLE);
  assign commit = aw_held_ff && w_held_ff && (wr_state_ff == uec_pkg::UEC_WR_IDLE);
  assign wr_req_out = '{en: commit, addr: aw_addr_ff, data: w_data_ff, strb: w_strb_ff};
  // reads carry no side effect, so the decode may look at the live address
  assign s_axi_arready_out = !s_axi_rvalid_out;
  assign rd_en_out = s_axi_arvalid_in && s_axi_arready_out;
  assign rd_addr_out = s_axi_araddr_in;
  // write address and data capture, in either order
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      aw_addr_ff <= 8'h00;
      w_data_ff <= 32'h0000_0000;
      w_strb_ff <= 4'h0;
    end else if (commit) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_held_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_held_ff <= 1'b1;
        w_data_ff <= s_axi_wdata_in;
        w_strb_ff <= s_axi_wstrb_in;
      end
    end
  end
  // write response, one per committed write
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      wr_state_ff <= uec_pkg::UEC_WR_IDLE;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= `UEC_RESP_OKAY;
    end else begin
      case (wr_state_ff)
        uec_pkg::UEC_WR_IDLE: begin
          if (commit) begin
            wr_state_ff <= uec_pkg::UEC_WR_RESP;
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out <= wr_hit_in ? `UEC_RESP_OKAY : `UEC_RESP_SLVERR;
          end
        end
        uec_pkg::UEC_WR_RESP: begin
          if (s_axi_bready_in) begin
            wr_state_ff <= uec_pkg::UEC_WR_IDLE;
            s_axi_bvalid_out <= 1'b0;
          end
        end
        default: begin
          wr_state_ff <= uec_pkg::UEC_WR_IDLE;
          s_axi_bvalid_out <= 1'b0;
        end
      endcase
    end
  end
  // read data, unmapped reads answer zero with slverr
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h0000_0000;
      s_axi_rresp_out <= `UEC_RESP_OKAY;
    end else if (rd_en_out) begin
      s_axi_rvalid_out <= 1'b1;
      s_axi_rdata_out <= rd_hit_in ? rd_data_in : 32'h0000_0000;
      s_axi_rresp_out <= rd_hit_in ? `UEC_RESP_OKAY : `UEC_RESP_SLVERR;
    end else if (s_axi_rready_in) begin
      s_axi_rvalid_out <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: core/uec_usb_ctl_top.sv
// usb configuration and endpoint control register file with its control outputs
`timescale 1ns/1ps
`default_nettype none
`include "uec_map.svh"
module uec_usb_ctl_top #(
  parameter int EP_NUM = 16 // endpoint count
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  // axi4-lite read address
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // system power state, same clock domain
  input wire logic idle_mode_in,
  input wire logic sleep_mode_in,
  input wire logic host_mode_in,
  // transceiver drive from the serial engine
  input wire logic xcvr_drive_in,
  // token decision request from the protocol engine
  input wire uec_pkg::uec_tok_t tok_in,
  // stall event from the protocol engine
  input wire logic stall_set_in,
  input wire logic [3:0] stall_ep_in,
  // module power and test outputs
  output logic eye_test_out,
  output logic oe_monitor_out,
  output logic usb_halt_out,
  output logic usb_suspend_out,
  // token decision answer
  output logic tok_accept_out,
  output logic tok_stall_out,
  output logic tok_handshake_out,
  // host mode controls of endpoint zero
  output logic low_speed_direct_out,
  output logic pre_pid_required_out,
  output logic nak_retry_enable_out,
  // per endpoint direction enables
  output logic [EP_NUM-1:0] ep_rx_en_out,
  output logic [EP_NUM-1:0] ep_tx_en_out
);
  // bus side signals
  uec_pkg::uec_bus_req_t wr_req; // committed write
  logic wr_hit; // write address decodes
  logic rd_en; // read taken this cycle
  logic [7:0] rd_addr; // read address
  logic [31:0] rd_data; // read value
  logic rd_hit; // read address decodes
  logic wr_low; // write touches byte lane 0

  // register storage
  logic [7:0] cfg_ff; // usb_configuration_one
  logic [7:0] pwr_ff; // usb_power_control
  logic [7:0] ep_ff [EP_NUM]; // usb_endpoint_control array

  // registered control state
  logic halt_ff; // module stopped for idle
  logic suspend_ff; // module suspended
  logic oe_mon_ff; // observed drive enable
  logic nxt_suspend; // suspend request this cycle
  logic nxt_halt; // halt request this cycle

  // token decision helpers
  logic [7:0] tok_ep_reg; // control bits of the addressed endpoint
  logic tok_dir_ok; // direction allowed by the enables
  logic tok_live; // module able to answer tokens

  // true when the address is a word-aligned place in the endpoint window
  function automatic logic addr_is_ep(input logic [7:0] a);
    addr_is_ep = (a >= `UEC_EP_BASE) && (a <= `UEC_EP_LAST) && (a[1:0] == 2'b00);
  endfunction

  // endpoint number selected by a window address
  function automatic logic [3:0] ep_of(input logic [7:0] a);
    logic [7:0] off;
    off = a - `UEC_EP_BASE;
    ep_of = off[5:2];
  endfunction

  // true when the address names any register
  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (a == `UEC_CFG_OFS) || (a == `UEC_PWR_OFS) || addr_is_ep(a);
  endfunction

  // bus front end
  uec_axil_slave u_slave (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .s_axi_awaddr_in(s_axi_awaddr_in),
    .s_axi_awvalid_in(s_axi_awvalid_in),
    .s_axi_awready_out(s_axi_awready_out),
    .s_axi_wdata_in(s_axi_wdata_in),
    .s_axi_wstrb_in(s_axi_wstrb_in),
    .s_axi_wvalid_in(s_axi_wvalid_in),
    .s_axi_wready_out(s_axi_wready_out),
    .s_axi_bresp_out(s_axi_bresp_out),
    .s_axi_bvalid_out(s_axi_bvalid_out),
    .s_axi_bready_in(s_axi_bready_in),
    .s_axi_araddr_in(s_axi_araddr_in),
    .s_axi_arvalid_in(s_axi_arvalid_in),
    .s_axi_arready_out(s_axi_arready_out),
    .s_axi_rdata_out(s_axi_rdata_out),
    .s_axi_rresp_out(s_axi_rresp_out),
    .s_axi_rvalid_out(s_axi_rvalid_out),
    .s_axi_rready_in(s_axi_rready_in),
    .wr_req_out(wr_req),
    .wr_hit_in(wr_hit),
    .rd_en_out(rd_en),
    .rd_addr_out(rd_addr),
    .rd_data_in(rd_data),
    .rd_hit_in(rd_hit)
  );

  // decode of the committed write; all fields live in byte lane 0
  assign wr_hit = addr_hit(wr_req.addr);
  assign wr_low = wr_req.en && wr_req.strb[0];

  // configuration register, only implemented bits are stored
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      cfg_ff <= `UEC_RST_VAL;
    end else if (wr_low && (wr_req.addr == `UEC_CFG_OFS)) begin
      cfg_ff <= wr_req.data[7:0] & `UEC_CFG_MASK;
    end
  end

  // power control register, holds the software suspend bit
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      pwr_ff <= `UEC_RST_VAL;
    end else if (wr_low && (wr_req.addr == `UEC_PWR_OFS)) begin
      pwr_ff <= wr_req.data[7:0] & `UEC_PWR_MASK;
    end
  end

  // endpoint registers; the stall event is applied after the software
  // write so that a stall arriving during a clear is not lost
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      for (int i = 0; i < EP_NUM; i++) begin
        ep_ff[i] <= `UEC_RST_VAL;
      end
    end else begin
      for (int i = 0; i < EP_NUM; i++) begin
        // software write, reserved bit 5 dropped
        if (wr_low && addr_is_ep(wr_req.addr) && (ep_of(wr_req.addr) == 4'(i))) begin
          ep_ff[i] <= wr_req.data[7:0] & `UEC_EP_MASK;
        end
        // hardware marks the endpoint stalled, set wins
        if (stall_set_in && (stall_ep_in == 4'(i))) begin
          ep_ff[i][`UEC_EP_STALL] <= 1'b1;
        end
      end
    end
  end

  // read value, upper 24 bits and reserved positions are zero
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_hit = rd_en && addr_hit(rd_addr);
    if (rd_addr == `UEC_CFG_OFS) begin
      rd_data = {24'h00_0000, cfg_ff};
    end else if (rd_addr == `UEC_PWR_OFS) begin
      rd_data = {24'h00_0000, pwr_ff};
    end else if (addr_is_ep(rd_addr)) begin
      rd_data = {24'h00_0000, ep_ff[ep_of(rd_addr)]};
    end
  end

  // power requests: auto suspend only acts while sleeping, the
  // software bit acts on its own whatever the sleep state
  assign nxt_suspend = pwr_ff[`UEC_PWR_SUSP] ||
                       (cfg_ff[`UEC_CFG_ASUSP] && sleep_mode_in);
  assign nxt_halt = cfg_ff[`UEC_CFG_SIDL] && idle_mode_in;

  // module power state, one cycle behind its causes
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      suspend_ff <= 1'b0;
      halt_ff <= 1'b0;
    end else begin
      suspend_ff <= nxt_suspend;
      halt_ff <= nxt_halt;
    end
  end

  // suspend also stops the 48 mhz clock outside this block
  assign usb_suspend_out = suspend_ff;
  assign usb_halt_out = halt_ff;

  // drive enable monitor, registered so the pad sees a clean level;
  // it trails the engine's drive by one cycle
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      oe_mon_ff <= 1'b0;
    end else begin
      oe_mon_ff <= cfg_ff[`UEC_CFG_OEMON] && xcvr_drive_in;
    end
  end
  assign oe_monitor_out = oe_mon_ff;

  // eye pattern test request straight from its stored bit
  assign eye_test_out = cfg_ff[`UEC_CFG_EYE];

  // endpoint zero host controls; ignored when acting as a device
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      low_speed_direct_out <= 1'b0;
      pre_pid_required_out <= 1'b0;
      nak_retry_enable_out <= 1'b0;
    end else begin
      low_speed_direct_out <= host_mode_in && ep_ff[0][`UEC_EP_LSD];
      pre_pid_required_out <= host_mode_in && !ep_ff[0][`UEC_EP_LSD];
      nak_retry_enable_out <= host_mode_in && !ep_ff[0][`UEC_EP_RDIS];
    end
  end

  // per endpoint direction enables for the data path
  always_comb begin
    for (int i = 0; i < EP_NUM; i++) begin
      ep_rx_en_out[i] = ep_ff[i][`UEC_EP_RXEN];
      ep_tx_en_out[i] = ep_ff[i][`UEC_EP_TXEN];
    end
  end

  // token decision; a halted or suspended module answers nothing
  assign tok_ep_reg = ep_ff[tok_in.ep];
  assign tok_live = tok_in.valid && !halt_ff && !suspend_ff;

  // direction check; setup needs receive and is refused on a
  // bidirectional endpoint whose control disable bit is set
  always_comb begin
    case (tok_in.pid)
      uec_pkg::UEC_PID_OUT: begin
        tok_dir_ok = tok_ep_reg[`UEC_EP_RXEN];
      end
      uec_pkg::UEC_PID_IN: begin
        tok_dir_ok = tok_ep_reg[`UEC_EP_TXEN];
      end
      uec_pkg::UEC_PID_SETUP: begin
        tok_dir_ok = tok_ep_reg[`UEC_EP_RXEN] &&
                     !(tok_ep_reg[`UEC_EP_TXEN] && tok_ep_reg[`UEC_EP_CDIS]);
      end
      default: begin
        tok_dir_ok = 1'b0;
      end
    endcase
  end

  // a stalled endpoint answers stall instead of moving data
  assign tok_accept_out = tok_live && tok_dir_ok && !tok_ep_reg[`UEC_EP_STALL];
  assign tok_stall_out = tok_live && tok_dir_ok && tok_ep_reg[`UEC_EP_STALL];
  // handshake packets only where enabled, isochronous runs without
  assign tok_handshake_out = tok_live && tok_dir_ok && tok_ep_reg[`UEC_EP_HSHK];
endmodule
`default_nettype wire

// file: dv/uec_usb_ctl_monitor.sv
// port-level assertions for the usb control register block
`timescale 1ns/1ps
`default_nettype none
module uec_usb_ctl_monitor #(
  parameter int EP_NUM = 16 // endpoint count, handed on by the bind
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // register bus
  input wire logic s_axi_awvalid_in,
  input wire logic s_axi_awready_out,
  input wire logic s_axi_wvalid_in,
  input wire logic s_axi_wready_out,
  input wire logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // power state and engine side
  input wire logic idle_mode_in,
  input wire logic host_mode_in,
  input wire logic xcvr_drive_in,
  input wire uec_pkg::uec_tok_t tok_in,
  // control outputs
  input wire logic oe_monitor_out,
  input wire logic usb_halt_out,
  input wire logic usb_suspend_out,
  input wire logic tok_accept_out,
  input wire logic tok_stall_out,
  input wire logic tok_handshake_out,
  input wire logic low_speed_direct_out,
  input wire logic pre_pid_required_out,
  input wire logic nak_retry_enable_out,
  input wire logic [EP_NUM-1:0] ep_rx_en_out
);
  // everything here lives in the one bus clock domain
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);

  a_write_answer: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in &&
    s_axi_wready_out |-> ##2 s_axi_bvalid_out) else $error("write answer late");
  a_read_answer: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
    else $error("read answer late");
  a_read_upper_zero: assert property (s_axi_rvalid_out |-> s_axi_rdata_out[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  a_read_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out &&
    $stable(s_axi_rdata_out)) else $error("read data dropped early");
  a_write_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out &&
    $stable(s_axi_bresp_out)) else $error("write response dropped early");
  a_oe_needs_drive: assert property (!$past(xcvr_drive_in) |-> !oe_monitor_out)
    else $error("drive monitor high without drive");
  a_halt_needs_idle: assert property (!$past(idle_mode_in) |-> !usb_halt_out)
    else $error("halt outside idle");
  a_token_blocked: assert property (usb_halt_out || usb_suspend_out || !tok_in.valid |->
    !(tok_accept_out || tok_stall_out || tok_handshake_out)) else $error("token answered");
  a_accept_stall_excl: assert property (!(tok_accept_out && tok_stall_out))
    else $error("accept and stall together");
  a_host_speed_pair: assert property ($past(host_mode_in) && !$past(sys_rst_in) |->
    low_speed_direct_out != pre_pid_required_out) else $error("speed outputs not exclusive");
  a_device_mode_quiet: assert property (!$past(host_mode_in) |-> !(low_speed_direct_out ||
    pre_pid_required_out || nak_retry_enable_out)) else $error("host bits in device mode");
  a_rx_change_by_write: assert property (!$stable(ep_rx_en_out) |-> s_axi_bvalid_out)
    else $error("receive enables moved without write");
endmodule
`default_nettype wire

// file: dv/uec_engine_model.sv
// behavioural protocol engine that offers tokens, stalls and line drive
`timescale 1ns/1ps
`default_nettype none
module uec_engine_model (
  // clock
  input wire logic clk_in,
  // toward the control block
  output var uec_pkg::uec_tok_t tok_out,
  output logic stall_set_out,
  output logic [3:0] stall_ep_out,
  output logic xcvr_drive_out
);
  // quiet at time zero
  initial begin
    tok_out = '0;
    stall_set_out = 1'b0;
    stall_ep_out = 4'h0;
    xcvr_drive_out = 1'b0;
  end
  // offer one token and hold it until told otherwise
  task automatic offer(input logic [3:0] ep, input logic [1:0] pid);
    @(posedge clk_in);
    tok_out <= '{valid: 1'b1, ep: ep, pid: uec_pkg::uec_pid_t'(pid)};
  endtask
  // withdraw the token; the endpoint flips and the kind becomes in, so stale values never look valid
  task automatic drop();
    @(posedge clk_in);
    tok_out <= '{valid: 1'b0, ep: ~tok_out.ep, pid: uec_pkg::UEC_PID_IN};
  endtask
  // one cycle stall event
  task automatic stall(input logic [3:0] ep);
    @(posedge clk_in);
    stall_set_out <= 1'b1;
    stall_ep_out <= ep;
    @(posedge clk_in);
    stall_set_out <= 1'b0;
    stall_ep_out <= ~ep;
  endtask
  // line drive level
  task automatic drive(input logic b);
    @(posedge clk_in);
    xcvr_drive_out <= b;
  endtask
endmodule
`default_nettype wire

// file: dv/tb_top.sv
// self-checking bench for the usb control register block
`timescale 1ns/1ps
`default_nettype none
`include "uec_map.svh"
module tb_top;
  localparam int EP_NUM = 16; // endpoint count under test
  logic clk_in = 1'b0, sys_rst_in = 1'b1;
  logic [7:0] s_axi_awaddr_in = 8'h00, s_axi_araddr_in = 8'h00;
  logic [31:0] s_axi_wdata_in = 32'h00000000;
  logic [3:0] s_axi_wstrb_in = 4'hf; // full words only
  logic s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0, s_axi_bready_in = 1'b0;
  logic s_axi_arvalid_in = 1'b0, s_axi_rready_in = 1'b0;
  logic idle_mode_in = 1'b0, sleep_mode_in = 1'b0, host_mode_in = 1'b0;
  wire uec_pkg::uec_tok_t tok_in;
  wire logic stall_set_in, xcvr_drive_in;
  wire logic [3:0] stall_ep_in;
  logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
  logic s_axi_rvalid_out, eye_test_out, oe_monitor_out, usb_halt_out, usb_suspend_out;
  logic tok_accept_out, tok_stall_out, tok_handshake_out;
  logic low_speed_direct_out, pre_pid_required_out, nak_retry_enable_out;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
  logic [31:0] s_axi_rdata_out;
  logic [EP_NUM-1:0] ep_rx_en_out, ep_tx_en_out;
  int err_total = 0, check_count = 0;
  // token table: endpoint, kind, then expected accept, stall, handshake
  logic [8:0] ttab [0:8] = '{9'h065, 9'h06d, 9'h07d, 9'h0d8, 9'h0cd, 9'h0bc, 9'h0a8,
    9'h080, 9'h08c};

  uec_usb_ctl_top #(.EP_NUM(EP_NUM)) i_uec_usb_ctl_top (.clk_in, .sys_rst_in,
    .s_axi_awaddr_in, .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wdata_in, .s_axi_wstrb_in,
    .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in,
    .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out, .s_axi_rresp_out,
    .s_axi_rvalid_out, .s_axi_rready_in, .idle_mode_in, .sleep_mode_in, .host_mode_in,
    .xcvr_drive_in, .tok_in, .stall_set_in, .stall_ep_in, .eye_test_out, .oe_monitor_out,
    .usb_halt_out, .usb_suspend_out, .tok_accept_out, .tok_stall_out, .tok_handshake_out,
    .low_speed_direct_out, .pre_pid_required_out, .nak_retry_enable_out, .ep_rx_en_out,
    .ep_tx_en_out);
  uec_engine_model i_uec_engine_model (.clk_in, .tok_out(tok_in), .stall_set_out(stall_set_in),
    .stall_ep_out(stall_ep_in), .xcvr_drive_out(xcvr_drive_in));

  // 40 mhz bus clock
  initial begin
    forever #12.5 clk_in = ~clk_in;
  end
  // verdict and end of run
  task automatic finish_test();
    if (err_total == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // compare one value
  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one bus write; ready is looked at on the falling edge, where it is already settled
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic aw_t, w_t, b_t;
    logic [1:0] r;
    @(posedge clk_in);
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= d;
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    s_axi_bready_in <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(negedge clk_in);
      aw_t = s_axi_awvalid_in && s_axi_awready_out;
      w_t = s_axi_wvalid_in && s_axi_wready_out;
      b_t = s_axi_bvalid_out;
      r = s_axi_bresp_out;
      @(posedge clk_in);
      if (aw_t) s_axi_awvalid_in <= 1'b0;
      if (w_t) s_axi_wvalid_in <= 1'b0;
      if (b_t) begin
        s_axi_bready_in <= 1'b0;
        break;
      end
    end
    if (n == 40) begin
      err_total++;
      finish_test();
    end else check("write response", r, er);
  endtask
  // one bus read with expected data and response
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    logic a_t, r_t;
    @(posedge clk_in);
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'b1;
    s_axi_rready_in <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(negedge clk_in);
      a_t = s_axi_arvalid_in && s_axi_arready_out;
      r_t = s_axi_rvalid_out;
      if (r_t) check("read data", s_axi_rdata_out, ed);
      if (r_t) check("read response", s_axi_rresp_out, er);
      @(posedge clk_in);
      if (a_t) s_axi_arvalid_in <= 1'b0;
      if (r_t) begin
        s_axi_rready_in <= 1'b0;
        break;
      end
    end
    if (n == 40) begin
      err_total++;
      finish_test();
    end
  endtask
  // let registered outputs follow inputs changed at the last edge
  task automatic settle();
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
  endtask
  // main sequence
  initial begin
    logic [7:0] v;
    repeat (5) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    rd(`UEC_CFG_OFS, 32'h0, `UEC_RESP_OKAY);
    rd(`UEC_PWR_OFS, 32'h0, `UEC_RESP_OKAY);
    for (int i = 0; i < EP_NUM; i++) rd(`UEC_EP_BASE + 8'(4 * i), 32'h0, `UEC_RESP_OKAY);
    // unmapped and misaligned places answer with an error and zero data
    wr(8'h3c, 32'hffffffff, `UEC_RESP_SLVERR);
    rd(8'h80, 32'h0, `UEC_RESP_SLVERR);
    rd(8'h41, 32'h0, `UEC_RESP_SLVERR);
    // configuration bits and their outputs
    wr(`UEC_CFG_OFS, 32'hffffffff, `UEC_RESP_OKAY);
    rd(`UEC_CFG_OFS, 32'hd1, `UEC_RESP_OKAY);
    i_uec_engine_model.drive(1'b1);
    idle_mode_in <= 1'b1;
    sleep_mode_in <= 1'b1;
    settle();
    check("outputs cfg on", {eye_test_out, oe_monitor_out, usb_halt_out, usb_suspend_out},
      4'hf);
    wr(`UEC_CFG_OFS, 32'h0, `UEC_RESP_OKAY);
    settle();
    check("outputs cfg off", {eye_test_out, oe_monitor_out, usb_halt_out, usb_suspend_out},
      4'h0);
    wr(`UEC_PWR_OFS, 32'hffffffff, `UEC_RESP_OKAY);
    rd(`UEC_PWR_OFS, 32'h2, `UEC_RESP_OKAY);
    settle();
    check("software suspend", usb_suspend_out, 1'b1);
    wr(`UEC_PWR_OFS, 32'h0, `UEC_RESP_OKAY);
    idle_mode_in <= 1'b0;
    sleep_mode_in <= 1'b0;
    i_uec_engine_model.drive(1'b0);
    // every endpoint holds its own value; direction enables follow
    for (int i = 0; i < EP_NUM; i++) wr(`UEC_EP_BASE + 8'(4 * i), {24'hffffff, 8'(i * 29 + 37)},
      `UEC_RESP_OKAY);
    for (int i = 0; i < EP_NUM; i++) begin
      v = 8'(i * 29 + 37);
      rd(`UEC_EP_BASE + 8'(4 * i), {24'h0, v & `UEC_EP_MASK}, `UEC_RESP_OKAY);
      check("rx enable", ep_rx_en_out[i], v[3]);
      check("tx enable", ep_tx_en_out[i], v[2]);
    end
    // host mode controls of endpoint zero
    host_mode_in <= 1'b1;
    wr(`UEC_EP_BASE, 32'h80, `UEC_RESP_OKAY);
    settle();
    check("host lsd", {low_speed_direct_out, pre_pid_required_out, nak_retry_enable_out},
      3'h5);
    wr(`UEC_EP_BASE, 32'h40, `UEC_RESP_OKAY);
    settle();
    check("host hub", {low_speed_direct_out, pre_pid_required_out, nak_retry_enable_out},
      3'h2);
    host_mode_in <= 1'b0;
    settle();
    check("device mode", {low_speed_direct_out, pre_pid_required_out, nak_retry_enable_out},
      3'h0);
    // token decisions by endpoint setup
    wr(`UEC_EP_BASE + 8'h0c, 32'h0d, `UEC_RESP_OKAY);
    wr(`UEC_EP_BASE + 8'h10, 32'h04, `UEC_RESP_OKAY);
    wr(`UEC_EP_BASE + 8'h14, 32'h18, `UEC_RESP_OKAY);
    wr(`UEC_EP_BASE + 8'h18, 32'h1d, `UEC_RESP_OKAY);
    foreach (ttab[k]) begin
      i_uec_engine_model.offer(ttab[k][8:5], ttab[k][4:3]);
      @(negedge clk_in);
      check("token", {tok_accept_out, tok_stall_out, tok_handshake_out}, ttab[k][2:0]);
    end
    // stall event is stored and changes the answer
    i_uec_engine_model.stall(4'h3);
    rd(`UEC_EP_BASE + 8'h0c, 32'h0f, `UEC_RESP_OKAY);
    i_uec_engine_model.offer(4'h3, 2'h0);
    @(negedge clk_in);
    check("stalled token", {tok_accept_out, tok_stall_out, tok_handshake_out}, 3'h3);
    wr(`UEC_PWR_OFS, 32'h2, `UEC_RESP_OKAY);
    @(negedge clk_in);
    check("suspended token", {tok_accept_out, tok_stall_out, tok_handshake_out}, 3'h0);
    wr(`UEC_PWR_OFS, 32'h0, `UEC_RESP_OKAY);
    i_uec_engine_model.drop();
    @(negedge clk_in);
    check("no token", {tok_accept_out, tok_stall_out, tok_handshake_out}, 3'h0);
    finish_test();
  end
  // hang guard
  initial begin
    repeat (20000) @(posedge clk_in);
    err_total++;
    finish_test();
  end
endmodule
bind uec_usb_ctl_top uec_usb_ctl_monitor #(.EP_NUM(EP_NUM)) i_uec_usb_ctl_monitor (.clk_in,
  .sys_rst_in, .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wvalid_in, .s_axi_wready_out,
  .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_arvalid_in, .s_axi_arready_out,
  .s_axi_rdata_out, .s_axi_rvalid_out, .s_axi_rready_in, .idle_mode_in, .host_mode_in,
  .xcvr_drive_in, .tok_in, .oe_monitor_out, .usb_halt_out, .usb_suspend_out, .tok_accept_out,
  .tok_stall_out, .tok_handshake_out, .low_speed_direct_out, .pre_pid_required_out,
  .nak_retry_enable_out, .ep_rx_en_out);
`default_nettype wire
